/* core/phy_irq_pkg.sv */
// constants and types shared by the interrupt status block and its management port
package phy_irq_pkg;

   // ---------------------------------------------------------------
   // register indices on the management link
   // ---------------------------------------------------------------
   localparam logic [4:0]  REG_FLAGS        = 5'h1D;
   localparam logic [4:0]  REG_ENABLE       = 5'h1E;
   localparam logic [4:0]  REG_RESULT       = 5'h1F;

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int          FLAG_ENERGY      = 7;
   localparam int          FLAG_AN_DONE     = 6;
   localparam int          FLAG_REMOTE      = 5;
   localparam int          FLAG_LINK_DOWN   = 4;
   localparam int          FLAG_PARTNER_ACK = 3;
   localparam int          FLAG_PD_FAULT    = 2;
   localparam int          FLAG_PAGE        = 1;
   localparam logic [7:0]  FLAG_IMPL        = 8'hFE;
   localparam logic [7:0]  FLAGS_RST        = 8'h00;
   localparam logic [7:0]  ENABLE_RST       = 8'h00;
   localparam int          AUTODONE_BIT     = 12;
   localparam int          RSVD_LSB         = 5;
   localparam int          RSVD_W           = 7;
   localparam logic [6:0]  RSVD_RST         = 7'h02;
   localparam int          SPEED_LSB        = 2;
   localparam int          SPEED_W          = 3;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_KHZ          = 200000;
   localparam int          ENERGY_QUIET_MS  = 256;
   localparam int          ENERGY_QUIET_CYC = ENERGY_QUIET_MS * CLK_KHZ;

   // ---------------------------------------------------------------
   // management frame
   // ---------------------------------------------------------------
   localparam logic [5:0]  PREAMBLE_LEN     = 6'h20;
   localparam logic [4:0]  HDR_BITS         = 5'h0D;
   localparam logic [4:0]  WR_BITS          = 5'h12;
   localparam logic [4:0]  RD_BITS          = 5'h10;
   localparam logic [1:0]  OP_READ          = 2'h2;
   localparam logic [1:0]  OP_WRITE         = 2'h1;
   localparam logic [4:0]  PHY_ADDR_DEF     = 5'h01;

   typedef enum {MD_IDLE, MD_HDR, MD_TA, MD_RD, MD_WR} mdio_state_e;

endpackage : phy_irq_pkg

/* core/mdio_port.sv */
// serial management slave that reaches the interrupt status registers
`timescale 1ns/100ps
`default_nettype none
module mdio_port
   import phy_irq_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
)(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        mdc,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   output logic [4:0]       reg_addr,
   output logic             reg_rd,
   output logic             reg_wr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0]  mdc_s_r;
   logic [2:0]  mdio_s_r;
   logic        mdc_lvl_r;
   logic        mdc_lvl_nxt;
   logic        rise;
   logic        bit_in;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mdc_s_r   <= 3'h0;
         mdio_s_r  <= 3'h0;
         mdc_lvl_r <= 1'b0;
      end else begin
         mdc_s_r   <= {mdc_s_r[1:0], mdc};
         mdio_s_r  <= {mdio_s_r[1:0], mdio_in};
         mdc_lvl_r <= mdc_lvl_nxt;
      end
   end

   // a level only counts once stages two and three agree
   always_comb begin
      mdc_lvl_nxt = (mdc_s_r[1] == mdc_s_r[2]) ? mdc_s_r[2] : mdc_lvl_r;
      rise        = (mdc_s_r[1] == mdc_s_r[2]) & mdc_s_r[2] & ~mdc_lvl_r;
      bit_in      = mdio_s_r[2];
   end

   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   mdio_state_e state_r, state_nxt;
   logic [5:0]  ones_r, ones_nxt;
   logic [4:0]  cnt_r, cnt_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic [4:0]  addr_r, addr_nxt;
   logic        out_r, out_nxt;
   logic        oe_r, oe_nxt;

   always_comb begin
      state_nxt = state_r;
      ones_nxt  = ones_r;
      cnt_nxt   = cnt_r;
      sh_nxt    = sh_r;
      addr_nxt  = addr_r;
      out_nxt   = out_r;
      oe_nxt    = oe_r;
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      if (rise) begin
         case (state_r)
            MD_IDLE: begin
               if (bit_in) begin
                  ones_nxt = (ones_r == PREAMBLE_LEN) ? ones_r : ones_r + 6'h01;
               end else begin
                  if (ones_r == PREAMBLE_LEN) begin
                     state_nxt = MD_HDR;
                     cnt_nxt   = 5'h00;
                  end
                  ones_nxt = 6'h00;
               end
            end
            MD_HDR: begin
               sh_nxt  = {sh_r[14:0], bit_in};
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_nxt == HDR_BITS) begin
                  cnt_nxt   = 5'h00;
                  addr_nxt  = sh_nxt[4:0];
                  state_nxt = MD_IDLE;
                  // frames for another address are ignored silently
                  if (sh_nxt[12] && sh_nxt[9:5] == PHY_ADDR) begin
                     if (sh_nxt[11:10] == OP_READ) begin
                        state_nxt = MD_TA;
                     end else if (sh_nxt[11:10] == OP_WRITE) begin
                        state_nxt = MD_WR;
                     end
                  end
               end
            end
            MD_TA: begin
               // snapshot and clear-on-read happen in the same cycle
               reg_rd    = 1'b1;
               sh_nxt    = reg_rdata;
               oe_nxt    = 1'b1;
               out_nxt   = 1'b0;
               state_nxt = MD_RD;
            end
            MD_RD: begin
               if (cnt_r == RD_BITS) begin
                  oe_nxt    = 1'b0;
                  out_nxt   = 1'b0;
                  cnt_nxt   = 5'h00;
                  state_nxt = MD_IDLE;
               end else begin
                  out_nxt = sh_r[15];
                  sh_nxt  = {sh_r[14:0], 1'b0};
                  cnt_nxt = cnt_r + 5'h01;
               end
            end
            MD_WR: begin
               sh_nxt  = {sh_r[14:0], bit_in};
               cnt_nxt = cnt_r + 5'h01;
               if (cnt_nxt == WR_BITS) begin
                  reg_wr    = 1'b1;
                  cnt_nxt   = 5'h00;
                  state_nxt = MD_IDLE;
               end
            end
            default: begin
               state_nxt = MD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= MD_IDLE;
         ones_r  <= 6'h00;
         cnt_r   <= 5'h00;
         sh_r    <= 16'h0000;
         addr_r  <= 5'h00;
         out_r   <= 1'b0;
         oe_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ones_r  <= ones_nxt;
         cnt_r   <= cnt_nxt;
         sh_r    <= sh_nxt;
         addr_r  <= addr_nxt;
         out_r   <= out_nxt;
         oe_r    <= oe_nxt;
      end
   end

   assign mdio_out  = out_r;
   assign mdio_oe   = oe_r;
   assign reg_addr  = addr_r;
   assign reg_wdata = sh_nxt;

endmodule : mdio_port
`default_nettype wire

/* core/phy_interrupt_status.sv */
// event flags, enables and negotiation result of the transceiver
// Behaviour
// RQ1: energy-detected event sets flag bit 7
// RQ2: negotiation complete sets flag bit 6
// RQ3: partner remote fault sets flag bit 5
// RQ4: link down sets bit 4, follows link
// RQ5: partner acknowledge sets flag bit 3
// RQ6: parallel detection fault sets flag bit 2
// RQ7: page received sets flag bit 1
// RQ8: flag bits 15-8 and 0 read zero
// RQ9: flags latch until read, read clears stale
// RQ10: enable bits 7-0 writable, reset zero
// RQ11: enable upper byte reads zero, write zeros
// RQ12: interrupt while any enabled flag set
// RQ13: bit 12 shows negotiation done, else zero
// RQ14: bits 11-5 read-write, reset 0000010b
// RQ15: bits 4-2 give resolved speed, duplex
// RQ16: bits 15-13 and 1-0 read zero
// RQ17: energy drops after 256 ms quiet
`timescale 1ns/100ps
`default_nettype none
module phy_interrupt_status
   import phy_irq_pkg::*;
#(
   parameter int         QUIET_CYC = ENERGY_QUIET_CYC,
   parameter logic [4:0] PHY_ADDR  = PHY_ADDR_DEF
)(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe,
   input  wire logic       line_energy_seen,
   input  wire logic       link_up,
   input  wire logic       an_enabled,
   input  wire logic       an_done,
   input  wire logic       remote_fault,
   input  wire logic       partner_ack,
   input  wire logic       parallel_fault,
   input  wire logic       page_received,
   input  wire logic [2:0] resolved_speed_duplex,
   output logic            line_energy_present,
   output logic            phy_irq
);

   // ---------------------------------------------------------------
   // management port
   // ---------------------------------------------------------------
   logic [4:0]  reg_addr;
   logic        reg_rd;
   logic        reg_wr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;

   mdio_port #(.PHY_ADDR(PHY_ADDR)) u_port (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .mdc       (mdc),
      .mdio_in   (mdio_in),
      .mdio_out  (mdio_out),
      .mdio_oe   (mdio_oe),
      .reg_addr  (reg_addr),
      .reg_rd    (reg_rd),
      .reg_wr    (reg_wr),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [31:0] quiet_r, quiet_nxt;
   logic        energy_r, energy_nxt;
   logic        an_prev_r, an_prev_nxt;
   logic [7:0]  flags_r, flags_nxt;
   logic [7:0]  enable_r, enable_nxt;
   logic [6:0]  rsvd_r, rsvd_nxt;
   logic        irq_r, irq_nxt;
   logic [7:0]  cond;
   logic        rd_flags;
   logic        an_finished;

   always_comb begin
      an_finished = an_done & an_enabled;
      rd_flags    = reg_rd && (reg_addr == REG_FLAGS);
      // RQ17 quiet line timeout
      if (line_energy_seen) begin
         quiet_nxt  = 32'h0000_0000;
         energy_nxt = 1'b1;
      end else if (quiet_r >= 32'(QUIET_CYC - 1)) begin
         quiet_nxt  = quiet_r;
         energy_nxt = 1'b0;
      end else begin
         quiet_nxt  = quiet_r + 32'h0000_0001;
         energy_nxt = energy_r;
      end
      an_prev_nxt = an_finished;
      cond                   = 8'h00;
      // RQ1 energy rising edge
      cond[FLAG_ENERGY]      = energy_nxt & ~energy_r;
      // RQ2 negotiation done edge
      cond[FLAG_AN_DONE]     = an_finished & ~an_prev_r;
      // RQ3 remote fault level
      cond[FLAG_REMOTE]      = remote_fault;
      // RQ4 link down level
      cond[FLAG_LINK_DOWN]   = ~link_up;
      // RQ5 partner acknowledge level
      cond[FLAG_PARTNER_ACK] = partner_ack;
      // RQ6 parallel fault level
      cond[FLAG_PD_FAULT]    = parallel_fault;
      // RQ7 page received level
      cond[FLAG_PAGE]        = page_received;
      // RQ10 enable write path
      enable_nxt = (reg_wr && reg_addr == REG_ENABLE) ? reg_wdata[7:0] : enable_r;
      // RQ14 reserved field keeps what is written
      rsvd_nxt = (reg_wr && reg_addr == REG_RESULT) ? reg_wdata[RSVD_LSB +: RSVD_W] : rsvd_r;
      // RQ12 one cycle behind the flags, keeps the pin glitch free
      irq_nxt = |(flags_r & enable_r);
   end

   // RQ9 set wins over read clear
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         if (FLAG_IMPL[gi]) begin : g_impl
            assign flags_nxt[gi] = cond[gi] | (flags_r[gi] & ~rd_flags);
         end else begin : g_rsvd
            // RQ8 reserved bit stays zero
            assign flags_nxt[gi] = 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         quiet_r   <= 32'h0000_0000;
         energy_r  <= 1'b1;
         an_prev_r <= 1'b0;
         flags_r   <= FLAGS_RST;
         enable_r  <= ENABLE_RST;
         rsvd_r    <= RSVD_RST;
         irq_r     <= 1'b0;
      end else begin
         quiet_r   <= quiet_nxt;
         energy_r  <= energy_nxt;
         an_prev_r <= an_prev_nxt;
         flags_r   <= flags_nxt;
         enable_r  <= enable_nxt;
         rsvd_r    <= rsvd_nxt;
         irq_r     <= irq_nxt;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      // RQ16 reserved bits stay zero
      reg_rdata = 16'h0000;
      case (reg_addr)
         // RQ8 upper byte reads zero
         REG_FLAGS:  reg_rdata[7:0] = flags_r;
         // RQ11 upper byte reads zero
         REG_ENABLE: reg_rdata[7:0] = enable_r;
         REG_RESULT: begin
            // RQ13 done only when enabled
            reg_rdata[AUTODONE_BIT]           = an_finished;
            reg_rdata[RSVD_LSB +: RSVD_W]     = rsvd_r;
            // RQ15 resolved speed field
            reg_rdata[SPEED_LSB +: SPEED_W]   = resolved_speed_duplex;
         end
         default: reg_rdata = 16'h0000;
      endcase
   end

   assign line_energy_present = energy_r;
   assign phy_irq             = irq_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_energy_flag; $rose(energy_r) |-> flags_r[FLAG_ENERGY]; endproperty
   a_energy_flag: assert property (p_energy_flag) else $error("energy flag not set"); // RQ1
   property p_an_flag; $rose(an_finished) |=> flags_r[FLAG_AN_DONE]; endproperty
   a_an_flag: assert property (p_an_flag) else $error("negotiation flag not set"); // RQ2
   property p_link_flag; !link_up |=> flags_r[FLAG_LINK_DOWN]; endproperty
   a_link_flag: assert property (p_link_flag) else $error("link down flag not set"); // RQ4
   property p_flags_rsvd; reg_addr == REG_FLAGS |-> reg_rdata[15:8] == 8'h00 && !reg_rdata[0]; endproperty
   a_flags_rsvd: assert property (p_flags_rsvd) else $error("flag reserved bits nonzero"); // RQ8
   property p_hold; flags_r[FLAG_REMOTE] && !rd_flags |=> flags_r[FLAG_REMOTE] [*1]; endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without read"); // RQ9
   property p_clear; rd_flags && !partner_ack |=> !flags_r[FLAG_PARTNER_ACK]; endproperty
   a_clear: assert property (p_clear) else $error("stale flag survived read"); // RQ9
   property p_enable_wr; reg_wr && reg_addr == REG_ENABLE |=> enable_r == $past(reg_wdata[7:0]); endproperty
   a_enable_wr: assert property (p_enable_wr) else $error("enable write lost"); // RQ10
   property p_irq; (flags_r & enable_r) != 8'h00 |=> irq_r; endproperty
   a_irq: assert property (p_irq) else $error("interrupt does not track flags"); // RQ12
   property p_irq_low; (flags_r & enable_r) == 8'h00 |=> !irq_r; endproperty
   a_irq_low: assert property (p_irq_low) else $error("interrupt raised with nothing enabled"); // RQ12
   property p_remote_flag; remote_fault |=> flags_r[FLAG_REMOTE]; endproperty
   a_remote_flag: assert property (p_remote_flag) else $error("remote fault flag not set"); // RQ3
   property p_ack_flag; partner_ack |=> flags_r[FLAG_PARTNER_ACK]; endproperty
   a_ack_flag: assert property (p_ack_flag) else $error("acknowledge flag not set"); // RQ5
   property p_pd_flag; parallel_fault |=> flags_r[FLAG_PD_FAULT]; endproperty
   a_pd_flag: assert property (p_pd_flag) else $error("parallel fault flag not set"); // RQ6
   property p_page_flag; page_received |=> flags_r[FLAG_PAGE]; endproperty
   a_page_flag: assert property (p_page_flag) else $error("page flag not set"); // RQ7
   property p_enable_rsvd; reg_addr == REG_ENABLE |-> reg_rdata[15:8] == 8'h00; endproperty
   a_enable_rsvd: assert property (p_enable_rsvd) else $error("enable upper byte nonzero"); // RQ11
   property p_autodone; reg_addr == REG_RESULT |-> reg_rdata[AUTODONE_BIT] == (an_done && an_enabled); endproperty
   a_autodone: assert property (p_autodone) else $error("done bit wrong"); // RQ13
   property p_result_rsvd; reg_addr == REG_RESULT |-> reg_rdata[15:13] == 3'h0 && reg_rdata[1:0] == 2'h0; endproperty
   a_result_rsvd: assert property (p_result_rsvd) else $error("status reserved bits nonzero"); // RQ16
   property p_energy_on; line_energy_seen |=> energy_r ##1 energy_r; endproperty
   a_energy_on: assert property (p_energy_on) else $error("energy not held after activity"); // RQ17

   c_read_flags: cover property (rd_flags && flags_r != 8'h00);
   c_enable_wr:  cover property (reg_wr && reg_addr == REG_ENABLE);
   c_irq:        cover property ($rose(irq_r));
   c_quiet:      cover property ($fell(energy_r));

endmodule : phy_interrupt_status
`default_nettype wire

/* tb/mgmt_model.sv */
// management controller model that frames reads and writes on the serial link
`timescale 1ns/100ps
`default_nettype none
module mgmt_model
   import phy_irq_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic mdio_line,
   output logic      mdc,
   output logic      drv_en,
   output logic      drv_val
);
   initial begin
      mdc = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b0;
   end
   // ---------------------------------------------------------------
   // one mdc period: data set while low, line sampled just before rise
   // ---------------------------------------------------------------
   task automatic bit_cyc(input logic en, input logic val, output logic smp);
      @(negedge ref_clk);
      mdc = 1'b0;
      drv_en = en;
      drv_val = val;
      repeat (5) @(negedge ref_clk);
      smp = mdio_line;
      mdc = 1'b1;
      repeat (5) @(negedge ref_clk);
   endtask : bit_cyc
   // preamble, start, opcode, phy and register address, msb first
   task automatic header(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra);
      logic [45:0] hdr;
      logic        s;
      hdr = {32'hFFFFFFFF, 2'h1, op, phy, ra};
      for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
   endtask : header
   // mdc parked low between frames, line let go to its pull-up
   task automatic park();
      @(negedge ref_clk);
      mdc = 1'b0;
      drv_en = 1'b0;
   endtask : park
   task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
      logic [17:0] tail;
      logic        s;
      header(phy, OP_WRITE, ra);
      tail = {2'h2, d};
      for (int i = 17; i >= 0; i--) bit_cyc(1'b1, tail[i], s);
      park();
   endtask : wr
   // released for both turnaround bits and all data bits
   task automatic rd(input logic [4:0] phy, input logic [4:0] ra, output logic [15:0] d);
      logic [17:0] smp;
      header(phy, OP_READ, ra);
      for (int i = 17; i >= 0; i--) bit_cyc(1'b0, 1'b1, smp[i]);
      d = smp[15:0];
      park();
   endtask : rd
endmodule : mgmt_model
`default_nettype wire

/* tb/phy_interrupt_status_tb_top.sv */
// self-checking bench for the event flags, enables and negotiation result
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin err_total++; \
   $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module phy_interrupt_status_tb_top
   import phy_irq_pkg::*;
;
   localparam int QC = 50;
   logic        ref_clk, nrst, mdc, mdio_in, mdio_out, mdio_oe, drv_en, drv_val, mdio_line;
   logic        line_energy_seen, link_up, an_enabled, an_done, remote_fault;
   logic        partner_ack, parallel_fault, page_received, line_energy_present, phy_irq;
   logic [2:0]  resolved_speed_duplex;
   logic [31:0] rnd;
   logic [7:0]  en, ev;
   logic [2:0]  spd_tab [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
   int          err_total, check_count;
   // pull-up wins when nobody drives
   assign mdio_line = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
   assign mdio_in   = mdio_line;
   phy_interrupt_status #(.QUIET_CYC(QC)) u_phy_interrupt_status (
      .ref_clk(ref_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .line_energy_seen(line_energy_seen), .link_up(link_up),
      .an_enabled(an_enabled), .an_done(an_done), .remote_fault(remote_fault),
      .partner_ack(partner_ack), .parallel_fault(parallel_fault), .page_received(page_received),
      .resolved_speed_duplex(resolved_speed_duplex), .line_energy_present(line_energy_present),
      .phy_irq(phy_irq));
   mgmt_model u_mgmt_model (.ref_clk(ref_clk), .mdio_line(mdio_line), .mdc(mdc),
      .drv_en(drv_en), .drv_val(drv_val));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   function automatic logic [15:0] exp_result(input logic ae, input logic ad, input logic [2:0] s);
      return {3'h0, ae & ad, RSVD_RST, s, 2'h0};
   endfunction : exp_result
   task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] d;
      u_mgmt_model.rd(phy, ra, d);
      `CHK("reg_read", exp, d)
   endtask : rd_chk
   task automatic set_src(input int b, input logic v);
      case (b)
         FLAG_REMOTE:      remote_fault = v;
         FLAG_LINK_DOWN:   link_up = !v;
         FLAG_PARTNER_ACK: partner_ack = v;
         FLAG_PD_FAULT:    parallel_fault = v;
         FLAG_PAGE:        page_received = v;
         default:          an_done = v;
      endcase
   endtask : set_src
   // one-cycle events, so a read finds every cause gone
   task automatic pulse(input logic [7:0] e);
      @(negedge ref_clk);
      for (int b = 1; b < 7; b++) if (e[b]) set_src(b, 1'b1);
      @(negedge ref_clk);
      for (int b = 1; b < 7; b++) if (e[b]) set_src(b, 1'b0);
      repeat (4) @(negedge ref_clk);
   endtask : pulse
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   // ---------------------------------------------------------------
   // clock, hang guard and main sequence
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      err_total++;
      wrap_up();
   end
   initial begin
      err_total = 0;
      check_count = 0;
      rnd = 32'hE571;
      nrst = 1'b0;
      {line_energy_seen, link_up, an_enabled} = 3'h7;
      {an_done, remote_fault, partner_ack, parallel_fault, page_received} = 5'h00;
      resolved_speed_duplex = 3'h1;
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (4) @(negedge ref_clk);
      `CHK("energy_rst", 1'b1, line_energy_present)
      `CHK("irq_rst", 1'b0, phy_irq)
      rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0000);
      rd_chk(PHY_ADDR_DEF, REG_ENABLE, 16'h0000);
      rd_chk(PHY_ADDR_DEF, REG_RESULT, exp_result(1'b1, 1'b0, 3'h1));
      rd_chk(5'h02, REG_FLAGS, 16'hFFFF);
      rd_chk(PHY_ADDR_DEF, 5'h1C, 16'h0000);
      // random enables and event mixes
      for (int n = 0; n < 12; n++) begin
         rnd = lfsr_next(rnd);
         en = (n == 0) ? 8'hFF : rnd[7:0];
         ev = (n == 0) ? 8'h7E : rnd[15:8] & 8'h7E;
         u_mgmt_model.wr(PHY_ADDR_DEF, REG_ENABLE, {8'h00, en});
         rd_chk(PHY_ADDR_DEF, REG_ENABLE, {8'h00, en});
         pulse(ev);
         `CHK("irq_set", |(ev & en), phy_irq)
         rd_chk(PHY_ADDR_DEF, REG_FLAGS, {8'h00, ev});
         rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0000);
         `CHK("irq_clr", 1'b0, phy_irq)
      end
      // link held down survives a read, then clears once restored
      link_up = 1'b0;
      rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0010);
      link_up = 1'b1;
      rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0010);
      rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0000);
      // quiet line drops the indication, returning energy flags it
      line_energy_seen = 1'b0;
      repeat (QC - 10) @(negedge ref_clk);
      `CHK("energy_hold", 1'b1, line_energy_present)
      repeat (20) @(negedge ref_clk);
      `CHK("energy_drop", 1'b0, line_energy_present)
      line_energy_seen = 1'b1;
      repeat (4) @(negedge ref_clk);
      `CHK("energy_back", 1'b1, line_energy_present)
      rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0080);
      // four speed codes, negotiation done and not
      u_mgmt_model.wr(PHY_ADDR_DEF, REG_RESULT, 16'h0040);
      for (int k = 0; k < 4; k++) begin
         resolved_speed_duplex = spd_tab[k];
         an_done = k[0];
         rd_chk(PHY_ADDR_DEF, REG_RESULT, exp_result(1'b1, k[0], spd_tab[k]));
      end
      an_enabled = 1'b0;
      rd_chk(PHY_ADDR_DEF, REG_RESULT, exp_result(1'b0, 1'b1, spd_tab[3]));
      // hardware reset mid-run: indication back to one, link flag follows the line
      line_energy_seen = 1'b0;
      link_up = 1'b0;
      repeat (QC + 10) @(negedge ref_clk);
      `CHK("energy_low_pre", 1'b0, line_energy_present)
      nrst = 1'b0;
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      `CHK("energy_hw_rst", 1'b1, line_energy_present)
      `CHK("irq_hw_rst", 1'b0, phy_irq)
      rd_chk(PHY_ADDR_DEF, REG_FLAGS, 16'h0010);
      rd_chk(PHY_ADDR_DEF, REG_ENABLE, 16'h0000);
      wrap_up();
   end
endmodule : phy_interrupt_status_tb_top
`default_nettype wire
